// *** common/rwf_pkg.sv ***
// constants and types shared by both ends of the panel command link
// assumes the device end counts addresses in units of one ram byte (eight pixels)
package rwf_pkg;
  // command codes
  localparam logic [7:0] CMD_WR_BW = 8'h24;
  localparam logic [7:0] CMD_WR_RED = 8'h26;
  localparam logic [7:0] CMD_RD_RAM = 8'h27;
  localparam logic [7:0] CMD_WIN_X = 8'h44;
  localparam logic [7:0] CMD_WIN_Y = 8'h45;
  localparam logic [7:0] CMD_FILL_RED = 8'h46;
  localparam logic [7:0] CMD_FILL_BW = 8'h47;
  localparam logic [7:0] CMD_ADDR_X = 8'h4E;
  localparam logic [7:0] CMD_ADDR_Y = 8'h4F;
  localparam logic [7:0] CMD_NOP = 8'h7F;

  // values after reset
  localparam logic [9:0] WIN_X_START_RST = 10'h000;
  localparam logic [9:0] WIN_X_END_RST = 10'h3BF;
  localparam logic [8:0] WIN_Y_START_RST = 9'h000;
  localparam logic [8:0] WIN_Y_END_RST = 9'h2A7;
  localparam logic [9:0] ADDR_RST = 10'h000;
  localparam logic [7:0] FILL_PARAM_RST = 8'h00;

  // fill parameter fields
  localparam int FILL_FIRST_BIT = 7;
  localparam int FILL_H_LSB = 4;
  localparam int FILL_W_LSB = 0;
  localparam logic [9:0] FILL_X_STEP = 10'h008;

  // host register map (byte addresses)
  localparam logic [7:0] REG_TX = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam int TX_DC_BIT = 8;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_DROP_BIT = 2;
  localparam int CTRL_RESET_BIT = 0;

  // host link timing in clk cycles
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [3:0] GAP_LAST = 4'hF;

  typedef enum logic [3:0] {
    STR_NONE = 4'b0001,
    STR_BW = 4'b0010,
    STR_RED = 4'b0100,
    STR_RD = 4'b1000
  } rwf_stream_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SHIFT = 3'b010,
    H_GAP = 3'b100
  } rwf_hstate_t;

  function automatic logic [9:0] step_width(input logic [2:0] code);
    logic [9:0] w;
    w = 10'h008;
    unique case (code)
      3'h0: w = 10'h008;
      3'h1: w = 10'h010;
      3'h2: w = 10'h020;
      3'h3: w = 10'h040;
      3'h4: w = 10'h080;
      3'h5: w = 10'h100;
      3'h6: w = 10'h200;
      3'h7: w = 10'h2A8;
    endcase
    return w;
  endfunction

  function automatic logic [9:0] step_height(input logic [2:0] code);
    logic [9:0] h;
    h = 10'h008;
    unique case (code)
      3'h0: h = 10'h008;
      3'h1: h = 10'h010;
      3'h2: h = 10'h020;
      3'h3: h = 10'h040;
      3'h4: h = 10'h080;
      3'h5: h = 10'h100;
      3'h6: h = 10'h200;
      3'h7: h = 10'h3C0;
    endcase
    return h;
  endfunction
endpackage

// *** common/rwf_link_if.sv ***
// serial command link between host controller and panel device
// host makes sclk; the device samples mosi and dc on sclk rising edges
`timescale 1ns/1ps
interface rwf_link_if;
  logic sclk;
  logic cs_n;
  logic dc;
  logic mosi;
  logic hardware_reset_n;
  logic busy;

  modport device (
    input sclk,
    input cs_n,
    input dc,
    input mosi,
    input hardware_reset_n,
    output busy
  );

  modport host (
    output sclk,
    output cs_n,
    output dc,
    output mosi,
    output hardware_reset_n,
    input busy
  );
endinterface

// *** verilog/rwf_dev.sv ***
// panel device end: byte receiver on sclk, command decoder and pattern fill on CLK
// assumes the host sends whole bytes, msb first, dc steady during each byte
// How it works
// - 0x45 takes four Y window bytes
// - Y window start nine bits, resets zero
// - Y window end resets to 0x2A7
// - 0x46 fills red RAM, bit7 first value
// - bits 6:4 pick step height
// - busy high while a fill runs
// - 0x47 fills black/white RAM likewise
// - 0x4E loads X counter, two bytes
// - 0x4F loads Y counter, two bytes
// - 0x7F accepted, changes no setting
// - no-operation ends RAM streaming
// - after 0x24 bytes go to black/white RAM
// - after 0x26 bytes go to red RAM
// - X window resets 0 and 0x3BF
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module rwf_dev (
  input wire logic CLK,
  input wire logic RST,
  rwf_link_if.device LNK,
  output logic RAM_WE,
  output logic RAM_RED,
  output logic [9:0] RAM_X,
  output logic [9:0] RAM_Y,
  output logic [7:0] RAM_DATA,
  output logic [9:0] WIN_X_START,
  output logic [9:0] WIN_X_END,
  output logic [8:0] WIN_Y_START,
  output logic [8:0] WIN_Y_END,
  output logic [9:0] ADDR_X,
  output logic [9:0] ADDR_Y,
  output logic [7:0] FILL_PARAM,
  output logic BUSY
);
  // link domain: byte assembly
  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] rx_byte;
  logic rx_dc;
  logic rx_tog;

  // a byte cut short by cs_n rising leaves bit_cnt off; the host never does that
  always_ff @(posedge LNK.sclk or posedge RST) begin
    if (RST) begin
      bit_cnt <= 3'h0;
      shreg <= 7'h00;
      rx_byte <= 8'h00;
      rx_dc <= 1'b0;
      rx_tog <= 1'b0;
    end else if (!LNK.cs_n) begin
      shreg <= {shreg[5:0], LNK.mosi};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        rx_byte <= {shreg, LNK.mosi};
        rx_dc <= LNK.dc;
        rx_tog <= ~rx_tog;
      end
    end
  end

  // crossing: toggle event, rx_byte and rx_dc stay put for a whole byte time
  logic [2:0] tog_s;
  logic tog_seen;
  logic [2:0] hr_s;
  logic hr_f;
  wire byte_ev = (tog_s[1] == tog_s[2]) && (tog_s[2] != tog_seen);
  wire pin_reset = ~hr_f;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog_s <= 3'h0;
      tog_seen <= 1'b0;
      hr_s <= 3'h7;
      hr_f <= 1'b1;
    end else begin
      tog_s <= {tog_s[1:0], rx_tog};
      if (tog_s[1] == tog_s[2]) begin
        tog_seen <= tog_s[2];
      end
      hr_s <= {hr_s[1:0], LNK.hardware_reset_n};
      if (hr_s[1] == hr_s[2]) begin
        hr_f <= hr_s[2];
      end
    end
  end

  // command decoding
  logic [7:0] cmd;
  logic [2:0] idx;
  rwf_pkg::rwf_stream_t stream;
  logic filling;

  wire is_cmd = byte_ev && !rx_dc && !filling;
  wire is_par = byte_ev && rx_dc && !filling;
  wire p0 = is_par && (idx == 3'h0);
  wire p1 = is_par && (idx == 3'h1);
  wire p2 = is_par && (idx == 3'h2);
  wire p3 = is_par && (idx == 3'h3);
  wire c_winx = (cmd == rwf_pkg::CMD_WIN_X);
  wire c_winy = (cmd == rwf_pkg::CMD_WIN_Y);
  wire c_fill = (cmd == rwf_pkg::CMD_FILL_RED) || (cmd == rwf_pkg::CMD_FILL_BW);
  wire c_ax = (cmd == rwf_pkg::CMD_ADDR_X);
  wire c_ay = (cmd == rwf_pkg::CMD_ADDR_Y);
  wire ram_wr = is_par && ((stream == rwf_pkg::STR_BW) || (stream == rwf_pkg::STR_RED));
  wire fill_go = p0 && c_fill;

  // stream pointer advance inside the window
  wire x_at_end = (ADDR_X == WIN_X_END);
  wire y_at_end = (ADDR_Y == {1'b0, WIN_Y_END});
  wire [9:0] next_ax = x_at_end ? WIN_X_START : ADDR_X + 10'h001;
  wire [9:0] next_ay = !x_at_end ? ADDR_Y : (y_at_end ? {1'b0, WIN_Y_START} : ADDR_Y + 10'h001);

  // any command byte but 0x24, 0x26 and 0x27, the no-operation included, ends streaming
  rwf_pkg::rwf_stream_t next_stream;
  always_comb begin
    next_stream = rwf_pkg::STR_NONE;
    if (rx_byte == rwf_pkg::CMD_WR_BW) begin
      next_stream = rwf_pkg::STR_BW;
    end else if (rx_byte == rwf_pkg::CMD_WR_RED) begin
      next_stream = rwf_pkg::STR_RED;
    end else if (rx_byte == rwf_pkg::CMD_RD_RAM) begin
      next_stream = rwf_pkg::STR_RD;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd <= rwf_pkg::CMD_NOP;
      idx <= 3'h0;
      stream <= rwf_pkg::STR_NONE;
    end else if (pin_reset) begin
      cmd <= rwf_pkg::CMD_NOP;
      idx <= 3'h0;
      stream <= rwf_pkg::STR_NONE;
    end else if (is_cmd) begin
      // no-operation only lands in cmd and stream, no setting moves
      cmd <= rx_byte;
      idx <= 3'h0;
      stream <= next_stream;
    end else if (is_par && idx != 3'h7) begin
      idx <= idx + 3'h1;
    end
  end

  // window and counter settings
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WIN_X_START <= rwf_pkg::WIN_X_START_RST;
      WIN_X_END <= rwf_pkg::WIN_X_END_RST;
      WIN_Y_START <= rwf_pkg::WIN_Y_START_RST;
      WIN_Y_END <= rwf_pkg::WIN_Y_END_RST;
      ADDR_X <= rwf_pkg::ADDR_RST;
      ADDR_Y <= rwf_pkg::ADDR_RST;
      FILL_PARAM <= rwf_pkg::FILL_PARAM_RST;
    end else if (pin_reset) begin
      WIN_X_START <= rwf_pkg::WIN_X_START_RST;
      WIN_X_END <= rwf_pkg::WIN_X_END_RST;
      WIN_Y_START <= rwf_pkg::WIN_Y_START_RST;
      WIN_Y_END <= rwf_pkg::WIN_Y_END_RST;
      ADDR_X <= rwf_pkg::ADDR_RST;
      ADDR_Y <= rwf_pkg::ADDR_RST;
      FILL_PARAM <= rwf_pkg::FILL_PARAM_RST;
    end else begin
      if (c_winx && p0) WIN_X_START[7:0] <= rx_byte;
      if (c_winx && p1) WIN_X_START[9:8] <= rx_byte[1:0];
      if (c_winx && p2) WIN_X_END[7:0] <= rx_byte;
      if (c_winx && p3) WIN_X_END[9:8] <= rx_byte[1:0];
      if (c_winy && p0) WIN_Y_START[7:0] <= rx_byte;
      if (c_winy && p1) WIN_Y_START[8] <= rx_byte[0];
      if (c_winy && p2) WIN_Y_END[7:0] <= rx_byte;
      if (c_winy && p3) WIN_Y_END[8] <= rx_byte[0];
      if (fill_go) FILL_PARAM <= rx_byte;
      if (ram_wr) begin
        ADDR_X <= next_ax;
        ADDR_Y <= next_ay;
      end else begin
        if (c_ax && p0) ADDR_X[7:0] <= rx_byte;
        if (c_ax && p1) ADDR_X[9:8] <= rx_byte[1:0];
        if (c_ay && p0) ADDR_Y[7:0] <= rx_byte;
        if (c_ay && p1) ADDR_Y[9:8] <= rx_byte[1:0];
      end
    end
  end

  // pattern fill over the current window, one byte per CLK
  logic fill_red;
  logic [9:0] fx;
  logic [9:0] fy;
  logic [9:0] wc;
  logic [9:0] hc;
  logic xv;
  logic yv;
  wire [9:0] step_w = rwf_pkg::step_width(FILL_PARAM[rwf_pkg::FILL_W_LSB +: 3]);
  wire [9:0] step_h = rwf_pkg::step_height(FILL_PARAM[rwf_pkg::FILL_H_LSB +: 3]);
  wire first_v = rx_byte[rwf_pkg::FILL_FIRST_BIT];
  wire f_row_end = (fx == WIN_X_END);
  wire f_last = f_row_end && (fy == {1'b0, WIN_Y_END});
  wire [9:0] next_wc = wc + rwf_pkg::FILL_X_STEP;
  wire w_flip = (next_wc >= step_w);
  wire h_flip = ((hc + 10'h001) == step_h);
  wire next_yv = h_flip ? ~yv : yv;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      filling <= 1'b0;
      fill_red <= 1'b0;
      fx <= 10'h000;
      fy <= 10'h000;
      wc <= 10'h000;
      hc <= 10'h000;
      xv <= 1'b0;
      yv <= 1'b0;
    end else if (pin_reset) begin
      filling <= 1'b0;
    end else if (fill_go) begin
      filling <= 1'b1;
      fill_red <= (cmd == rwf_pkg::CMD_FILL_RED);
      fx <= WIN_X_START;
      fy <= {1'b0, WIN_Y_START};
      wc <= 10'h000;
      hc <= 10'h000;
      xv <= first_v;
      yv <= first_v;
    end else if (filling) begin
      if (f_last) begin
        filling <= 1'b0;
      end else if (f_row_end) begin
        fx <= WIN_X_START;
        fy <= fy + 10'h001;
        wc <= 10'h000;
        hc <= h_flip ? 10'h000 : hc + 10'h001;
        yv <= next_yv;
        xv <= next_yv;
      end else begin
        fx <= fx + 10'h001;
        wc <= w_flip ? 10'h000 : next_wc;
        if (w_flip) xv <= ~xv;
      end
    end
  end

  // ram write port shared by streaming and fill; they never overlap
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAM_WE <= 1'b0;
      RAM_RED <= 1'b0;
      RAM_X <= 10'h000;
      RAM_Y <= 10'h000;
      RAM_DATA <= 8'h00;
      BUSY <= 1'b0;
    end else begin
      RAM_WE <= (ram_wr || filling) && !pin_reset;
      BUSY <= filling && !pin_reset;
      if (filling) begin
        RAM_RED <= fill_red;
        RAM_X <= fx;
        RAM_Y <= fy;
        RAM_DATA <= {8{xv}};
      end else if (ram_wr) begin
        RAM_RED <= (stream == rwf_pkg::STR_RED);
        RAM_X <= ADDR_X;
        RAM_Y <= ADDR_Y;
        RAM_DATA <= rx_byte;
      end
    end
  end

  assign LNK.busy = BUSY;
endmodule

// *** verilog/rwf_host.sv ***
// host controller end: AHB-Lite register slave driving the serial command link
// assumes a single AHB master doing single word transfers; sclk is CLK divided by four
`timescale 1ns/1ps
module rwf_host (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  rwf_link_if.host LNK
);
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic [8:0] tx_last;
  logic ctrl_reset;
  logic drop;
  rwf_pkg::rwf_hstate_t state;
  logic [1:0] ph;
  logic [2:0] bitn;
  logic [6:0] sh;
  logic [3:0] gap;
  logic [2:0] busy_s;
  logic busy_f;
  logic sclk_q;
  logic cs_n_q;
  logic dc_q;
  logic mosi_q;
  logic rst_n_q;

  wire sel_ap = HSEL && HREADY && HTRANS[1];
  wire wr_tx = ap_valid && ap_write && (ap_addr == rwf_pkg::REG_TX);
  wire wr_ctrl = ap_valid && ap_write && (ap_addr == rwf_pkg::REG_CTRL);
  wire wr_stat = ap_valid && ap_write && (ap_addr == rwf_pkg::REG_STATUS);
  wire tx_is_cmd = !HWDATA[rwf_pkg::TX_DC_BIT];
  // a command byte while the device is busy is refused
  wire tx_ok = (state == rwf_pkg::H_IDLE) && !(tx_is_cmd && busy_f);
  wire start = wr_tx && tx_ok;
  wire [31:0] st_word = {29'h0, drop, busy_f, (state != rwf_pkg::H_IDLE)};
  wire [31:0] rd_word = (HADDR[7:0] == rwf_pkg::REG_TX) ? {23'h0, tx_last} :
                        (HADDR[7:0] == rwf_pkg::REG_STATUS) ? st_word :
                        (HADDR[7:0] == rwf_pkg::REG_CTRL) ? {31'h0, ctrl_reset} : 32'h0;

  // zero wait slave: read data is fetched in the address phase
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      ap_valid <= sel_ap;
      ap_write <= HWRITE;
      ap_addr <= HADDR[7:0];
      HRDATA <= (sel_ap && !HWRITE) ? rd_word : 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_last <= 9'h000;
      ctrl_reset <= 1'b0;
      drop <= 1'b0;
    end else begin
      if (start) tx_last <= HWDATA[8:0];
      if (wr_ctrl) ctrl_reset <= HWDATA[rwf_pkg::CTRL_RESET_BIT];
      // a new refusal wins over a clear in the same cycle
      if (wr_tx && !tx_ok) begin
        drop <= 1'b1;
      end else if (wr_stat && HWDATA[rwf_pkg::ST_DROP_BIT]) begin
        drop <= 1'b0;
      end
    end
  end

  // busy pin from the device, three flops and agreement filter
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_s <= 3'h0;
      busy_f <= 1'b0;
    end else begin
      busy_s <= {busy_s[1:0], LNK.busy};
      if (busy_s[1] == busy_s[2]) busy_f <= busy_s[2];
    end
  end

  // byte shifter; the long gap lets a fill's busy reach busy_f before the next command
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= rwf_pkg::H_IDLE;
      ph <= 2'h0;
      bitn <= 3'h0;
      sh <= 7'h00;
      gap <= 4'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      dc_q <= 1'b0;
      mosi_q <= 1'b0;
      rst_n_q <= 1'b1;
    end else begin
      rst_n_q <= ~ctrl_reset;
      unique case (state)
        rwf_pkg::H_IDLE: begin
          if (start) begin
            state <= rwf_pkg::H_SHIFT;
            cs_n_q <= 1'b0;
            dc_q <= HWDATA[rwf_pkg::TX_DC_BIT];
            mosi_q <= HWDATA[7];
            sh <= HWDATA[6:0];
            bitn <= 3'h0;
            ph <= 2'h0;
          end
        end
        rwf_pkg::H_SHIFT: begin
          ph <= ph + 2'h1;
          if (ph == rwf_pkg::PH_RISE) sclk_q <= 1'b1;
          if (ph == rwf_pkg::PH_FALL) begin
            sclk_q <= 1'b0;
            if (bitn == 3'h7) begin
              state <= rwf_pkg::H_GAP;
              cs_n_q <= 1'b1;
              gap <= 4'h0;
            end else begin
              mosi_q <= sh[6];
              sh <= {sh[5:0], 1'b0};
              bitn <= bitn + 3'h1;
            end
          end
        end
        rwf_pkg::H_GAP: begin
          gap <= gap + 4'h1;
          if (gap == rwf_pkg::GAP_LAST) state <= rwf_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign LNK.sclk = sclk_q;
  assign LNK.cs_n = cs_n_q;
  assign LNK.dc = dc_q;
  assign LNK.mosi = mosi_q;
  assign LNK.hardware_reset_n = rst_n_q;
endmodule

// *** sim/rwf_link_properties.sv ***
// link checker: framing, bit cells and busy behaviour on the serial command link
// assumes sclk is made from CLK by the host, so every link signal is sampled on CLK
`timescale 1ns/1ps
module rwf_link_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dc,
  input wire logic mosi,
  input wire logic hardware_reset_n,
  input wire logic busy
);
  logic sclk_q;
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  // counts sclk rises inside a frame, cleared while deselected
  assign next_rise_cnt = cs_n ? 4'h0 : ((sclk && !sclk_q) ? rise_cnt + 4'h1 : rise_cnt);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_q <= 1'b0;
      rise_cnt <= 4'h0;
    end else begin
      sclk_q <= sclk;
      rise_cnt <= next_rise_cnt;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_bit_cell;
    sclk [*2] ##1 !sclk;
  endsequence
  sequence s_frame_open;
    !sclk ##[1:3] sclk;
  endsequence

  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk moved outside a frame");
  chk_dc_frame_stable: assert property (!cs_n && !$past(cs_n) |-> $stable(dc))
    else $error("dc changed inside a frame");
  chk_mosi_hold_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi changed while sclk high");
  chk_bit_cell_shape: assert property ($rose(sclk) |-> s_bit_cell)
    else $error("sclk high phase not two cycles");
  chk_frame_open_edge: assert property ($fell(cs_n) |-> s_frame_open)
    else $error("first sclk rise late after select");
  chk_frame_eight_bits: assert property ($rose(cs_n) |-> rise_cnt == 4'h8)
    else $error("frame did not carry eight bits");
  chk_frame_gap_min: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("gap between frames too short");
  chk_busy_ends_bound: assert property ($rose(busy) |-> ##[1:1000] !busy)
    else $error("busy stuck high");
  chk_cmd_not_busy: assert property ($fell(cs_n) && !dc |-> !busy)
    else $error("command sent while busy");
  chk_busy_hw_reset: assert property (!hardware_reset_n [*8] |-> !busy)
    else $error("busy high during hardware reset");
endmodule

// *** sim/testbench.sv ***
// self-checking bench: host and device ends joined by the link, driven over AHB-Lite
// assumes both ends share CLK; fills run on small windows to keep the run short
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin cmp_count++; if ((act) !== (exp)) begin failures++; $display("mismatch at %0t: %s", $time, msg); end end
module testbench;
  logic clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ram_we, ram_red, busy_o, wr_red, busy_seen;
  logic [9:0] ram_x, ram_y, win_x_start, win_x_end, addr_x, addr_y, wr_x, wr_y;
  logic [8:0] win_y_start, win_y_end;
  logic [7:0] ram_data, fill_param;
  logic [7:0] wr_data [0:255];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int wr_n = 0;
  int base;
  rwf_link_if lnk();
  rwf_host rwf_host_inst (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .LNK(lnk.host));
  rwf_dev rwf_dev_inst (.CLK(clk), .RST(rst), .LNK(lnk.device), .RAM_WE(ram_we), .RAM_RED(ram_red),
    .RAM_X(ram_x), .RAM_Y(ram_y), .RAM_DATA(ram_data), .WIN_X_START(win_x_start), .WIN_X_END(win_x_end),
    .WIN_Y_START(win_y_start), .WIN_Y_END(win_y_end), .ADDR_X(addr_x), .ADDR_Y(addr_y),
    .FILL_PARAM(fill_param), .BUSY(busy_o));
  rwf_link_properties rwf_link_properties_inst (.CLK(clk), .RST(rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .dc(lnk.dc), .mosi(lnk.mosi), .hardware_reset_n(lnk.hardware_reset_n), .busy(lnk.busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ram_we === 1'b1) begin
      wr_data[wr_n % 256] <= ram_data;
      wr_red <= ram_red;
      wr_x <= ram_x;
      wr_y <= ram_y;
      wr_n <= wr_n + 1;
    end
    if (busy_o === 1'b1) begin
      busy_seen <= 1'b1;
    end
  end

  // one single word transfer; hready is polled rather than assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    hsize <= 3'b010;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic poll(input int bitpos);
    int n;
    n = 0;
    do begin
      ahb(1'b0, rwf_pkg::REG_STATUS, 32'h00000000, q);
      n++;
    end while (q[bitpos] !== 1'b0 && n < 500);
    // a poll that gives up must not pass silently
    `CHK(q[bitpos], 1'b0, "status bit stuck high")
  endtask

  task automatic cmd(input logic [7:0] c, input int np, input logic [31:0] p);
    ahb(1'b1, rwf_pkg::REG_TX, {23'h000000, 1'b0, c}, q);
    poll(rwf_pkg::ST_ACTIVE_BIT);
    for (int i = 0; i < np; i++) begin
      ahb(1'b1, rwf_pkg::REG_TX, {23'h000000, 1'b1, p[8*i +: 8]}, q);
      poll(rwf_pkg::ST_ACTIVE_BIT);
    end
  endtask

  // checkerboard expectation: first value flipped per width step in x and height step in y
  task automatic fill(input logic [7:0] c, input logic [7:0] prm, input logic [9:0] xe, input logic [8:0] ye);
    int nx;
    logic v;
    cmd(rwf_pkg::CMD_WIN_X, 4, {6'h00, xe, 16'h0000});
    cmd(rwf_pkg::CMD_WIN_Y, 4, {7'h00, ye, 16'h0000});
    busy_seen = 1'b0;
    base = wr_n;
    nx = xe + 1;
    cmd(c, 1, {24'h000000, prm});
    poll(rwf_pkg::ST_BUSY_BIT);
    `CHK(wr_n - base, nx * (ye + 1), "fill write count")
    `CHK(busy_seen, 1'b1, "busy not raised by fill")
    `CHK(wr_red, c == rwf_pkg::CMD_FILL_RED, "fill went to wrong ram")
    `CHK(fill_param, prm, "fill parameter not held")
    `CHK({wr_x, wr_y}, {xe, 1'b0, ye}, "fill last address")
    for (int i = 0; i < nx * (ye + 1); i++) begin
      v = prm[7] ^ (((i % nx) >> prm[2:0]) % 2 == 1) ^ (((i / nx) >> (prm[6:4] + 3)) % 2 == 1);
      `CHK(wr_data[(base + i) % 256], {8{v}}, "fill pattern")
    end
  endtask

  task automatic print_verdict;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    busy_seen = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    `CHK(win_y_start, 9'h000, "y start reset")
    `CHK(win_y_end, 9'h2A7, "y end reset")
    `CHK({win_x_start, win_x_end}, {10'h000, 10'h3BF}, "x window reset")
    `CHK({addr_x, addr_y, fill_param}, 28'h0000000, "counters reset")
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
    ahb(1'b0, 8'h0C, 32'h00000000, q);
    `CHK(q, 32'h00000000, "unmapped read not zero")
    cmd(rwf_pkg::CMD_WIN_Y, 4, 32'h01FF0134);
    `CHK({win_y_start, win_y_end}, {9'h134, 9'h1FF}, "y window load")
    cmd(rwf_pkg::CMD_ADDR_X, 2, 32'h00000355);
    cmd(rwf_pkg::CMD_ADDR_Y, 2, 32'h000000AA);
    `CHK({addr_x, addr_y}, {10'h355, 10'h0AA}, "address counter load")
    cmd(rwf_pkg::CMD_NOP, 0, 32'h00000000);
    `CHK({addr_x, addr_y, win_y_start, win_y_end}, {10'h355, 10'h0AA, 9'h134, 9'h1FF}, "nop changed state")
    base = wr_n;
    cmd(rwf_pkg::CMD_WR_BW, 1, 32'h0000005A);
    `CHK({wr_data[base % 256], wr_red, wr_x, wr_y}, {8'h5A, 1'b0, 10'h355, 10'h0AA}, "bw stream")
    `CHK(addr_x, 10'h356, "x pointer advance")
    cmd(rwf_pkg::CMD_WR_RED, 1, 32'h000000C3);
    `CHK({wr_data[(base + 1) % 256], wr_red}, {8'hC3, 1'b1}, "red stream")
    cmd(rwf_pkg::CMD_NOP, 1, 32'h00000011);
    `CHK(wr_n - base, 2, "data after nop still written")
    cmd(rwf_pkg::CMD_RD_RAM, 1, 32'h00000033);
    `CHK(wr_n - base, 2, "data after read command written")
    fill(rwf_pkg::CMD_FILL_BW, 8'h80, 10'h007, 9'h000);
    fill(rwf_pkg::CMD_FILL_BW, 8'h01, 10'h007, 9'h000);
    fill(rwf_pkg::CMD_FILL_BW, 8'h02, 10'h007, 9'h000);
    fill(rwf_pkg::CMD_FILL_RED, 8'h00, 10'h000, 9'h00F);
    fill(rwf_pkg::CMD_FILL_RED, 8'h90, 10'h001, 9'h00F);
    // a 32 byte fill keeps busy up long enough for the next command to meet it
    cmd(rwf_pkg::CMD_FILL_RED, 1, 32'h00000000);
    ahb(1'b1, rwf_pkg::REG_TX, {23'h000000, 1'b0, rwf_pkg::CMD_ADDR_X}, q);
    ahb(1'b0, rwf_pkg::REG_STATUS, 32'h00000000, q);
    `CHK(q[2:1], 2'b11, "command while busy not refused")
    ahb(1'b0, rwf_pkg::REG_TX, 32'h00000000, q);
    `CHK(q, 32'h00000100, "refused byte latched")
    poll(rwf_pkg::ST_BUSY_BIT);
    ahb(1'b1, rwf_pkg::REG_STATUS, 32'h00000004, q);
    ahb(1'b0, rwf_pkg::REG_STATUS, 32'h00000000, q);
    `CHK(q[2], 1'b0, "drop flag not cleared")
    ahb(1'b1, rwf_pkg::REG_CTRL, 32'h00000001, q);
    repeat (20) @(posedge clk);
    `CHK({win_y_start, win_y_end, fill_param}, {9'h000, 9'h2A7, 8'h00}, "hardware reset values")
    `CHK({win_x_end, addr_x}, {10'h3BF, 10'h000}, "hardware reset x")
    ahb(1'b1, rwf_pkg::REG_CTRL, 32'h00000000, q);
    repeat (10) @(posedge clk);
    print_verdict();
  end
endmodule
